// ### cfg_pin_mux_params.svh
// Constants for the configuration pin multiplexer.
// Assumes inclusion by bare name from any design file of this block.
`ifndef CFG_PIN_MUX_PARAMS_SVH
`define CFG_PIN_MUX_PARAMS_SVH

`define MODE_JTAG_ONLY     3'h5
`define MODE_SLAVE_SERIAL  3'h7
`define MODE_MASTER_SERIAL 3'h0
`define MODE_MASTER_SPI    3'h1
`define SPI_WIDTH_X1       2'h0
`define SPI_WIDTH_X2       2'h1
`define SPI_WIDTH_X4       2'h2
`define REV_SELECT_RESET   2'h0

`endif

// ### cfg_pin_mux_pkg.sv
// Types shared by the configuration pin multiplexer files.
// Assumes cfg_pin_mux_params.svh is on the include path.
`include "cfg_pin_mux_params.svh"

package cfg_pin_mux_pkg;

   // ========================================
   // Decoded configuration modes
   typedef enum logic [2:0] {
      CFG_NONE          = 3'h0,
      CFG_JTAG_ONLY     = 3'h1,
      CFG_SLAVE_SERIAL  = 3'h2,
      CFG_MASTER_SERIAL = 3'h3,
      CFG_MASTER_SPI    = 3'h4
   } cfg_mode_t;

endpackage

// ### cfg_mode_if.sv
// Carries the decoded mode between decoder and pin multiplexer.
// Assumes one clock domain shared by both ends.
`timescale 1ns/100ps
`default_nettype none

interface cfg_mode_if;
   cfg_pin_mux_pkg::cfg_mode_t mode;
   logic                       mode_valid;
   modport decoder (output mode, output mode_valid);
   modport user    (input mode, input mode_valid);
endinterface

`default_nettype wire

// ### cfg_mode_decoder.sv
// Samples the mode-select pins once per configuration cycle.
// Assumes mode pins synchronous to clk_i and a one-cycle start pulse.
`timescale 1ns/100ps
`default_nettype none
`include "cfg_pin_mux_params.svh"

module cfg_mode_decoder (
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       sys_rst_i,
   // Configuration control
   input  wire logic       cfg_start_i,
   input  wire logic       cfg_end_i,
   input  wire logic [2:0] mode_select_i,
   // Decoded mode
   cfg_mode_if.decoder     mode_o
);

   // ========================================
   // Mode capture
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         mode_o.mode       <= cfg_pin_mux_pkg::CFG_NONE;
         mode_o.mode_valid <= 1'b0;
      end else if (cfg_start_i) begin
         mode_o.mode_valid <= 1'b1;
         unique case (mode_select_i)
            `MODE_JTAG_ONLY:     mode_o.mode <= cfg_pin_mux_pkg::CFG_JTAG_ONLY;
            `MODE_SLAVE_SERIAL:  mode_o.mode <= cfg_pin_mux_pkg::CFG_SLAVE_SERIAL;
            `MODE_MASTER_SERIAL: mode_o.mode <= cfg_pin_mux_pkg::CFG_MASTER_SERIAL;
            `MODE_MASTER_SPI:    mode_o.mode <= cfg_pin_mux_pkg::CFG_MASTER_SPI;
            default:             mode_o.mode <= cfg_pin_mux_pkg::CFG_NONE;
         endcase
      end else if (cfg_end_i) begin
         mode_o.mode_valid <= 1'b0;
      end
   end

   // ========================================
   // Checks
   mode_hold_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      !cfg_start_i |=> $stable(mode_o.mode))
      else $error("decoded mode changed without a start");
   mode_decode_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      cfg_start_i && mode_select_i == `MODE_MASTER_SPI
      |=> mode_o.mode == cfg_pin_mux_pkg::CFG_MASTER_SPI)
      else $error("master SPI code not decoded");

endmodule

`default_nettype wire

// ### config_mode_pin_mux.sv
// Configuration pin multiplexer: picks the active pin set per mode.
// Assumes all inputs synchronous to clk_i; pad wires resolved outside.
`timescale 1ns/100ps
`default_nettype none
`include "cfg_pin_mux_params.svh"

module config_mode_pin_mux (
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       sys_rst_i,
   // Configuration sequence
   input  wire logic [2:0] mode_select_i,
   input  wire logic       cfg_start_i,
   input  wire logic       cfg_end_i,
   input  wire logic [1:0] spi_width_i,
   // Options
   input  wire logic       persist_option_i,
   input  wire logic       debug_stream_option_i,
   input  wire logic       external_clock_option_i,
   input  wire logic       fallback_option_i,
   input  wire logic       serial_chain_i,
   input  wire logic       parallel_chain_i,
   // Events and core data
   input  wire logic       multi_image_boot_i,
   input  wire logic       fallback_event_i,
   input  wire logic [1:0] rev_select_value_i,
   input  wire logic       core_flash_cs_n_i,
   input  wire logic [3:0] core_data_out_i,
   input  wire logic       core_data_drive_i,
   input  wire logic       core_dout_i,
   input  wire logic       core_downstream_cs_n_i,
   input  wire logic       internal_clock_i,
   // Pads
   input  wire logic [3:0] data_pad_i,
   input  wire logic       external_master_clock_in_i,
   output logic      [3:0] data_pad_o,
   output logic      [3:0] data_pad_oe_n_o,
   output logic            flash_chip_select_n_o,
   output logic            flash_chip_select_n_oe_n_o,
   output logic            dout_o,
   output logic            dout_oe_n_o,
   output logic            downstream_chip_select_n_o,
   output logic            downstream_chip_select_n_oe_n_o,
   output logic      [1:0] revision_select_outputs_o,
   output logic      [1:0] revision_select_outputs_oe_n_o,
   // Status to core
   output logic      [3:0] core_data_in_o,
   output logic            master_clock_sel_o,
   output logic            dedicated_pins_active_o,
   output logic            cfg_active_o
);

   cfg_mode_if mode_bus ();

   cfg_mode_decoder u_decoder (
      .clk_i         (clk_i),
      .sys_rst_i     (sys_rst_i),
      .cfg_start_i   (cfg_start_i),
      .cfg_end_i     (cfg_end_i),
      .mode_select_i (mode_select_i),
      .mode_o        (mode_bus.decoder)
   );

   // ========================================
   // Pin set selection
   logic       pins_on;
   logic       is_spi;
   logic       is_serial;
   logic       is_master;
   logic       rev_ev;
   logic [1:0] spi_w_q;

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         spi_w_q <= `SPI_WIDTH_X1;
      end else if (cfg_start_i) begin
         spi_w_q <= spi_width_i;
      end
   end

   assign pins_on   = mode_bus.mode_valid || persist_option_i;
   assign is_spi    = pins_on
                      && mode_bus.mode == cfg_pin_mux_pkg::CFG_MASTER_SPI;
   assign is_master = pins_on
                      && (mode_bus.mode == cfg_pin_mux_pkg::CFG_MASTER_SPI
                      || mode_bus.mode == cfg_pin_mux_pkg::CFG_MASTER_SERIAL);
   assign is_serial = is_master
                      || (pins_on && mode_bus.mode
                          == cfg_pin_mux_pkg::CFG_SLAVE_SERIAL);
   assign rev_ev    = multi_image_boot_i
                      || (fallback_event_i && fallback_option_i);

   // ========================================
   // Flash chip select and data pins
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         flash_chip_select_n_o      <= 1'b1;
         flash_chip_select_n_oe_n_o <= 1'b1;
         data_pad_o                 <= 4'h0;
         data_pad_oe_n_o            <= 4'hF;
      end else begin
         flash_chip_select_n_o      <= core_flash_cs_n_i;
         flash_chip_select_n_oe_n_o <= !is_spi;
         data_pad_o                 <= core_data_out_i;
         data_pad_oe_n_o            <= 4'hF;
         if (is_spi) begin
            unique case (spi_w_q)
               `SPI_WIDTH_X1: data_pad_oe_n_o <= 4'hE;
               `SPI_WIDTH_X2:
                  data_pad_oe_n_o <= {2'h3, {2{!core_data_drive_i}}};
               default:
                  data_pad_oe_n_o <= {4{!core_data_drive_i}};
            endcase
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         core_data_in_o <= 4'h0;
      end else begin
         core_data_in_o <= 4'h0;
         if (is_serial && !is_spi) begin
            core_data_in_o <= {3'h0, data_pad_i[1]};
         end else if (is_spi) begin
            unique case (spi_w_q)
               `SPI_WIDTH_X1: core_data_in_o <= {3'h0, data_pad_i[1]};
               `SPI_WIDTH_X2: core_data_in_o <= {2'h0, data_pad_i[1:0]};
               default:       core_data_in_o <= data_pad_i;
            endcase
         end
      end
   end

   // ========================================
   // Daisy chain and revision select
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         dout_o                          <= 1'b1;
         dout_oe_n_o                     <= 1'b1;
         downstream_chip_select_n_o      <= 1'b1;
         downstream_chip_select_n_oe_n_o <= 1'b1;
         revision_select_outputs_o       <= `REV_SELECT_RESET;
         revision_select_outputs_oe_n_o  <= 2'h3;
      end else begin
         dout_o      <= core_dout_i;
         dout_oe_n_o <= !((serial_chain_i && is_serial
                           && !(is_spi && spi_w_q != `SPI_WIDTH_X1))
                          || debug_stream_option_i);
         downstream_chip_select_n_o      <= core_downstream_cs_n_i;
         downstream_chip_select_n_oe_n_o <= !parallel_chain_i;
         revision_select_outputs_o       <= rev_select_value_i;
         revision_select_outputs_oe_n_o  <= {2{!(rev_ev && !is_spi)}};
      end
   end

   // ========================================
   // Master clock source and dedicated pins
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         master_clock_sel_o      <= 1'b0;
         dedicated_pins_active_o <= 1'b1;
         cfg_active_o            <= 1'b0;
      end else begin
         master_clock_sel_o      <= is_master && external_clock_option_i;
         dedicated_pins_active_o <= 1'b1;
         cfg_active_o            <= mode_bus.mode_valid;
      end
   end

   // ========================================
   // Checks
   flash_cs_mode_a: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      !flash_chip_select_n_oe_n_o |-> $past(is_spi))
      else $error("flash select driven outside SPI mode");
   dout_gate_a: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      !dout_oe_n_o |-> $past(serial_chain_i || debug_stream_option_i))
      else $error("serial output driven without chain or debug");
   cso_gate_a: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      !downstream_chip_select_n_oe_n_o |-> $past(parallel_chain_i))
      else $error("downstream select driven outside parallel chain");
   rev_gate_a: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      revision_select_outputs_oe_n_o != 2'h3 |-> $past(rev_ev))
      else $error("revision select driven without event");
   ext_clk_a: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      master_clock_sel_o |-> $past(external_clock_option_i))
      else $error("external clock used without option");
   unused_hiz_a: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      !$past(is_spi) |-> data_pad_oe_n_o == 4'hF)
      else $error("data pad driven outside SPI mode");
   dedicated_on_a: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      ##1 dedicated_pins_active_o)
      else $error("dedicated pins released");
   persist_keep_a: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      persist_option_i && mode_bus.mode == cfg_pin_mux_pkg::CFG_MASTER_SPI
      |=> !flash_chip_select_n_oe_n_o)
      else $error("persist did not keep SPI pins");
   spi_rev_off_a: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      is_spi |=> revision_select_outputs_oe_n_o == 2'h3)
      else $error("revision select driven in SPI mode");
   x1_pin_set_a: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      is_spi && spi_w_q == `SPI_WIDTH_X1 |=> data_pad_oe_n_o == 4'hE)
      else $error("single-lane SPI pin set wrong");
   ext_clk_use_a: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      is_master && external_clock_option_i |=> master_clock_sel_o)
      else $error("external clock option not honoured");
   core_in_quiet_a: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      !is_serial |=> core_data_in_o == 4'h0)
      else $error("input data taken outside a serial mode");

endmodule

`default_nettype wire

// ### flash_partner.sv
// Serial flash model facing the configuration pad multiplexer.
// Assumes pad enables are low while the device drives a pad.
`timescale 1ns/100ps
`default_nettype none

module flash_partner (
   // Clock and device side
   input  wire logic       clk_i,
   input  wire logic       cs_n_i,
   input  wire logic       cs_oe_n_i,
   input  wire logic [3:0] dev_d_i,
   input  wire logic [3:0] dev_oe_n_i,
   // Resolved pad level
   output logic      [3:0] pad_o
);
   logic [3:0] drv_q = 4'hA;
   logic [3:0] last_q = 4'h5;

   // Fresh data while selected, else inverse of last level
   always @(posedge clk_i) begin
      last_q <= pad_o;
      if (!cs_oe_n_i && !cs_n_i) drv_q <= 4'($urandom);
      else drv_q <= ~last_q;
   end

   // Each data pad carries device data where its enable is low, else model data
   always_comb begin
      for (int i = 0; i < 4; i++)
         pad_o[i] = dev_oe_n_i[i] ? drv_q[i] : dev_d_i[i];
   end
endmodule

`default_nettype wire

// ### tb_config_mode_pin_mux.sv
// Self-checking bench for the configuration pad multiplexer.
// Assumes the design files and the params header are compiled first.
`timescale 1ns/100ps
`default_nettype none
`include "cfg_pin_mux_params.svh"

module tb_config_mode_pin_mux;
   logic clk_i, sys_rst_i, cfg_start_i, cfg_end_i, persist_option_i;
   logic debug_stream_option_i, external_clock_option_i, fallback_option_i;
   logic serial_chain_i, parallel_chain_i, multi_image_boot_i;
   logic fallback_event_i, core_flash_cs_n_i, core_data_drive_i;
   logic core_dout_i, core_downstream_cs_n_i, internal_clock_i;
   logic external_master_clock_in_i, flash_chip_select_n_o, dout_o;
   logic flash_chip_select_n_oe_n_o, dout_oe_n_o, master_clock_sel_o;
   logic downstream_chip_select_n_o, downstream_chip_select_n_oe_n_o;
   logic dedicated_pins_active_o, cfg_active_o;
   logic [3:0] core_data_out_i, data_pad_i, data_pad_o, data_pad_oe_n_o;
   logic [3:0] core_data_in_o;
   logic [2:0] mode_select_i, cm;
   logic [1:0] spi_width_i, rev_select_value_i, cw;
   logic [1:0] revision_select_outputs_o, revision_select_outputs_oe_n_o;
   logic [12:0] e, k;
   logic [3:0] pd;
   int bad_count = 0;
   int n_compared = 0;
   int cyc = 0;
   wire [12:0] seen = {data_pad_oe_n_o, flash_chip_select_n_oe_n_o,
      dout_oe_n_o, downstream_chip_select_n_oe_n_o,
      revision_select_outputs_oe_n_o, master_clock_sel_o, cfg_active_o,
      dedicated_pins_active_o, flash_chip_select_n_o};
   wire [11:0] seen_data = {data_pad_o, dout_o, downstream_chip_select_n_o,
      revision_select_outputs_o, core_data_in_o};

   config_mode_pin_mux u_dut (.*);
   flash_partner u_flash (.clk_i(clk_i), .cs_n_i(flash_chip_select_n_o),
      .cs_oe_n_i(flash_chip_select_n_oe_n_o), .dev_d_i(data_pad_o),
      .dev_oe_n_i(data_pad_oe_n_o), .pad_o(data_pad_i));

   always #5 clk_i = ~clk_i;

   // ========================================
   // Expectation and checking
   function automatic logic [12:0] expect_pins(logic [2:0] m,
      logic [1:0] w, output logic [12:0] msk);
      logic spi, ser, drv;
      logic [3:0] doe;
      spi = (m == `MODE_MASTER_SPI);
      ser = (m == `MODE_SLAVE_SERIAL) || (m == `MODE_MASTER_SERIAL);
      drv = (w == `SPI_WIDTH_X1) || core_data_drive_i;
      doe = !spi ? 4'hF : (w == `SPI_WIDTH_X1) ? 4'hE : !drv ? 4'hF :
         (w == `SPI_WIDTH_X2) ? 4'hC : 4'h0;
      msk = {12'hFFF, spi};
      return {doe, !spi, !(debug_stream_option_i || serial_chain_i &&
         (ser || spi && w == `SPI_WIDTH_X1)), !parallel_chain_i,
         {2{!(!spi && (multi_image_boot_i || fallback_event_i &&
         fallback_option_i))}},
         external_clock_option_i && (spi || m == `MODE_MASTER_SERIAL),
         1'b1, 1'b1, spi ? core_flash_cs_n_i : 1'b1};
   endfunction

   function automatic logic [11:0] expect_data(logic [2:0] m,
      logic [1:0] w, logic [3:0] p);
      logic [3:0] din;
      din = 4'h0;
      if (m == `MODE_SLAVE_SERIAL || m == `MODE_MASTER_SERIAL)
         din = {3'h0, p[1]};
      else if (m == `MODE_MASTER_SPI)
         din = (w == `SPI_WIDTH_X1) ? {3'h0, p[1]} :
            (w == `SPI_WIDTH_X2) ? {2'h0, p[1:0]} : p;
      return {core_data_out_i, core_dout_i, core_downstream_cs_n_i,
         rev_select_value_i, din};
   endfunction

   task automatic cmp_data(string what, logic [11:0] ex);
      n_compared++;
      if (seen_data !== ex) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", what, ex,
            seen_data);
      end
   endtask

   task automatic cmp(string what, logic [12:0] ex, logic [12:0] msk);
      n_compared++;
      if (((seen ^ ex) & msk) !== 13'h0) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", what, ex & msk,
            seen & msk);
      end
   endtask

   task automatic shake();
      {persist_option_i, debug_stream_option_i, external_clock_option_i,
       fallback_option_i, serial_chain_i, parallel_chain_i,
       multi_image_boot_i, fallback_event_i, core_flash_cs_n_i,
       core_data_drive_i, core_dout_i, core_downstream_cs_n_i,
       internal_clock_i, external_master_clock_in_i} = 14'($urandom);
      {rev_select_value_i, core_data_out_i} = 6'($urandom);
      {mode_select_i, spi_width_i} = 5'($urandom);
   endtask

   task automatic end_of_test();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 2000) begin
         bad_count++;
         end_of_test();
      end
   end

   // ========================================
   // Main sequence
   initial begin
      clk_i = 1'b0;
      sys_rst_i = 1'b1;
      {cfg_start_i, cfg_end_i} = 2'h0;
      void'($urandom(32'hDA47));
      shake();
      repeat (2) @(negedge clk_i);
      cmp("reset", 13'h1FF3, 13'h1FFF);
      sys_rst_i = 1'b0;
      for (int i = 0; i < 64; i++) begin
         if (i == 40) begin
            sys_rst_i = 1'b1;
            @(negedge clk_i);
            cmp("mid reset", 13'h1FF3, 13'h1FFF);
            sys_rst_i = 1'b0;
         end
         shake();
         cm = (i < 32) ? 3'(i) : 3'($urandom);
         cw = (i < 32) ? 2'(i >> 3) : 2'($urandom);
         {mode_select_i, spi_width_i, cfg_start_i} = {cm, cw, 1'b1};
         @(negedge clk_i);
         cfg_start_i = 1'b0;
         mode_select_i = 3'($urandom);
         pd = data_pad_i;
         @(negedge clk_i);
         e = expect_pins(cm, cw, k);
         cmp("mode pins", e, k);
         cmp_data("mode data", expect_data(cm, cw, pd));
         pd = data_pad_i;
         shake();
         @(negedge clk_i);
         e = expect_pins(cm, cw, k);
         cmp("held mode", e, k);
         cmp_data("held data", expect_data(cm, cw, pd));
         if (i % 2 == 1) begin
            cfg_end_i = 1'b1;
            @(negedge clk_i);
            cfg_end_i = 1'b0;
            @(negedge clk_i);
            e = expect_pins(cm, cw, k);
            e = persist_option_i ? ((e & 13'h1F00) | 13'h2) : 13'h1F02;
            cmp("after end", e, 13'h1F06);
         end
      end
      end_of_test();
   end
endmodule

`default_nettype wire
